// ==== hw/ews_params.svh ====
// How it works
// - ready high: finish at phase one fall
// - ready low: add one cycle, hold bus
// - ignore ready on on-chip accesses
// - microstate low during phase one low
// - release data before memory drives it
// - sample ready once, early second half
`ifndef EWS_PARAMS_SVH
`define EWS_PARAMS_SVH

// clock and machine cycle timing
`define EWS_CLK_NS       4
`define EWS_QUARTER_NS   25
`define EWS_QUARTER_CYC  ((`EWS_QUARTER_NS + `EWS_CLK_NS - 1) / `EWS_CLK_NS)

// quarters of a machine cycle; phase one falls at quarter 0
`define EWS_Q_START      2'h0
`define EWS_Q_SAMPLE     2'h2

// bus widths and reset values
`define EWS_AW           16
`define EWS_DW           16
`define EWS_WAIT_W       8
`define EWS_ADDR_RST     16'h0000

`endif

// ==== hw/ews_pkg.sv ====
`default_nettype none
package ews_pkg;

	// address space of an access
	typedef enum logic [1:0] {
		EWS_SP_PROG = 2'h0,
		EWS_SP_DATA = 2'h1,
		EWS_SP_IO   = 2'h2
	} ews_space_t;

	// bus sequencer states
	typedef enum logic [1:0] {
		EWS_ST_IDLE = 2'h1,
		EWS_ST_ACC  = 2'h2
	} ews_state_t;

	// quarter timing from the phase generator
	typedef struct packed {
		logic [1:0] quarter;
		logic       tick;
	} ews_phase_t;

	// request from the core side
	typedef struct packed {
		logic       req;
		logic       we;
		logic       onchip;
		ews_space_t space;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ews_req_t;

	// external bus pins driven by the device
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] dout;
		logic        doe;
		logic        rw;
		logic        strobe_n;
		logic        prog_n;
		logic        data_n;
		logic        io_n;
		logic        msc_n;
		logic        ph1;
		logic        ph2;
	} ews_pins_t;

endpackage
`default_nettype wire

// ==== hw/ews_phase_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ews_params.svh"
module ews_phase_gen
	import ews_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_resetn,
	output ews_phase_t o_phase
);
	typedef struct packed {
		logic [7:0] cnt;
		ews_phase_t ph;
	} ews_pg_st_t;

	localparam logic [7:0] LAST = 8'(`EWS_QUARTER_CYC - 1);

	ews_pg_st_t st_r;
	ews_pg_st_t st_nxt;

	// quarter divider, tick marks the first clock of each quarter
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ph.tick = 1'b0;
		if (st_r.cnt == LAST)
		begin
			st_nxt.cnt = 8'h00;
			st_nxt.ph.quarter = st_r.ph.quarter + 2'h1;
			st_nxt.ph.tick = 1'b1;
		end
		else
			st_nxt.cnt = st_r.cnt + 8'h01;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			st_r <= '{cnt: LAST, ph: '{quarter: 2'h3, tick: 1'b0}};
		else
			st_r <= st_nxt;
	end

	assign o_phase = st_r.ph;
endmodule
`default_nettype wire

// ==== hw/ews_bus_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ews_params.svh"
module ews_bus_ctrl
	import ews_pkg::*;
(
	input  wire logic                    i_clk,
	input  wire logic                    i_resetn,
	input  wire ews_req_t                i_req,
	input  wire logic                    i_ready,
	input  wire logic [`EWS_DW-1:0]      i_data_in,
	output logic                         o_accept,
	output logic                         o_done,
	output logic [`EWS_DW-1:0]           o_rdata,
	output logic [`EWS_WAIT_W-1:0]       o_wait_count,
	output ews_pins_t                    o_pins
);
	typedef struct packed {
		ews_state_t            state;
		logic                  first;
		logic                  rdy_ok;
		ews_req_t              cur;
		logic [`EWS_DW-1:0]    rdata;
		logic                  done;
		logic [`EWS_WAIT_W-1:0] waits;
		ews_pins_t             pins;
	} ews_bc_st_t;

	ews_phase_t ph;
	ews_bc_st_t st_r;
	ews_bc_st_t st_nxt;
	logic       start;

	ews_phase_gen u_phase
	(
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.o_phase  (ph)
	);

	// select pin for a space, low while accessing it externally
	function automatic logic sel_n(input ews_bc_st_t s, input ews_space_t sp);
		sel_n = !(s.state == EWS_ST_ACC && !s.cur.onchip && s.cur.space == sp);
	endfunction

	// a new access may begin when phase one falls and the bus is idle or the current access ends
	assign start = ph.tick && ph.quarter == `EWS_Q_START && i_req.req &&
		(st_r.state == EWS_ST_IDLE || st_r.rdy_ok);
	assign o_accept = start;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		case (st_r.state)
			EWS_ST_IDLE:
			begin
				st_nxt.state = EWS_ST_IDLE;
			end
			EWS_ST_ACC:
			begin
				// single sample per machine cycle
				if (ph.tick && ph.quarter == `EWS_Q_SAMPLE)
				begin
					st_nxt.first = 1'b0;
					// on-chip space never waits
					st_nxt.rdy_ok = st_r.cur.onchip || i_ready;
				end
				if (ph.tick && ph.quarter == `EWS_Q_START)
				begin
					if (st_r.rdy_ok)
					begin
						// end at the phase one falling edge
						st_nxt.state = EWS_ST_IDLE;
						st_nxt.done = 1'b1;
						st_nxt.rdy_ok = 1'b0;
						if (!st_r.cur.we)
							st_nxt.rdata = i_data_in;
					end
					else
						// one more machine cycle, all pins but ph1 and ph2 held
						st_nxt.waits = st_r.waits + 8'h01;
				end
			end
			default:
			begin
				st_nxt.state = EWS_ST_IDLE;
			end
		endcase
		if (start)
		begin
			st_nxt.state = EWS_ST_ACC;
			st_nxt.first = 1'b1;
			st_nxt.rdy_ok = 1'b0;
			st_nxt.cur = i_req;
			st_nxt.waits = '0;
		end
		// pins follow the new state and the current quarter
		st_nxt.pins.ph1 = ph.quarter[1];
		st_nxt.pins.ph2 = ph.quarter == 2'h0 || ph.quarter == 2'h3;
		st_nxt.pins.addr = st_nxt.cur.addr;
		st_nxt.pins.rw = !(st_nxt.state == EWS_ST_ACC && st_nxt.cur.we);
		st_nxt.pins.prog_n = sel_n(st_nxt, EWS_SP_PROG);
		st_nxt.pins.data_n = sel_n(st_nxt, EWS_SP_DATA);
		st_nxt.pins.io_n = sel_n(st_nxt, EWS_SP_IO);
		// strobe stays low through wait cycles
		st_nxt.pins.strobe_n = !(st_nxt.state == EWS_ST_ACC &&
			!st_nxt.cur.onchip &&
			!(st_nxt.first && ph.quarter == `EWS_Q_START));
		// marks every operation's start, phase one low
		st_nxt.pins.msc_n = !(st_nxt.state == EWS_ST_ACC && st_nxt.first &&
			!ph.quarter[1]);
		// drive data only under strobe, released as strobe rises
		st_nxt.pins.doe = !st_nxt.pins.strobe_n && st_nxt.cur.we;
		st_nxt.pins.dout = st_nxt.cur.wdata;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			st_r <= '0;
			st_r.state <= EWS_ST_IDLE;
			st_r.cur.addr <= `EWS_ADDR_RST;
			st_r.pins.rw <= 1'b1;
			st_r.pins.strobe_n <= 1'b1;
			st_r.pins.prog_n <= 1'b1;
			st_r.pins.data_n <= 1'b1;
			st_r.pins.io_n <= 1'b1;
			st_r.pins.msc_n <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign o_done = st_r.done;
	assign o_rdata = st_r.rdata;
	assign o_wait_count = st_r.waits;
	assign o_pins = st_r.pins;

	// checks
	finish_on_ready_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_r.state == EWS_ST_ACC && st_r.rdy_ok && ph.tick &&
		ph.quarter == `EWS_Q_START) |=> (o_done && st_r.state != EWS_ST_ACC
		|| o_accept == 1'b0 && o_done))
		else $error("access did not end after ready high");

	wait_holds_bus_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_r.state == EWS_ST_ACC && !st_r.rdy_ok && !st_r.first && ph.tick &&
		ph.quarter == `EWS_Q_START && !st_r.cur.onchip)
		|=> !o_done && !o_pins.strobe_n && $stable(o_pins.addr))
		else $error("wait cycle changed the bus");

	onchip_no_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(st_r.state == EWS_ST_ACC && st_r.cur.onchip)
		|-> o_wait_count == 8'h00 && o_pins.strobe_n)
		else $error("on-chip access waited or strobed");

	msc_in_ph1_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!o_pins.msc_n |-> !o_pins.ph1)
		else $error("microstate low outside phase one low");

	msc_after_start_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		start |=> !o_pins.msc_n)
		else $error("operation start without microstate");

	data_release_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_pins.doe |-> !o_pins.strobe_n && !o_pins.rw)
		else $error("data driven outside write strobe");

	sample_quarter_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$rose(st_r.rdy_ok) |-> $past(ph.quarter) == `EWS_Q_SAMPLE)
		else $error("ready taken outside sampling point");

	cov_zero_wait: cover property (@(posedge i_clk) disable iff (!i_resetn)
		o_done && o_wait_count == 8'h00);
	cov_two_wait: cover property (@(posedge i_clk) disable iff (!i_resetn)
		o_done && o_wait_count == 8'h02);
	cov_back_to_back: cover property (@(posedge i_clk) disable iff (!i_resetn)
		start && st_r.state == EWS_ST_ACC);
endmodule
`default_nettype wire

// ==== testbench/ews_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ews_mem_model
	import ews_pkg::*;
(
	input  wire logic       i_clk,
	input  wire ews_pins_t  i_pins,
	output logic            o_ready,
	output logic [15:0]     o_data,
	output logic [15:0]     o_wr_data
);
	logic [2:0]  cyc_r = 3'h0;
	logic        ph1_r = 1'b0;
	logic [15:0] last_r = 16'h0000;
	logic        sel;
	logic        drv;
	logic [2:0]  nwait;
	// upper half none, lower banks one to four waits
	assign nwait = i_pins.addr[15] ? 3'h0
		: {1'b0, i_pins.addr[14:13]} + 3'h1;
	assign sel = !(i_pins.prog_n && i_pins.data_n && i_pins.io_n);
	// ready low until selected and enough cycles passed
	// zero-wait banks see ready high at once, as if tied high
	assign o_ready = sel && (cyc_r >= nwait);
	// memory drives only on selected reads
	assign drv = sel && i_pins.rw && !i_pins.strobe_n;
	// released bus toggles so stale data never matches
	assign o_data = drv ? ~i_pins.addr : ~last_r;
	// count phase one rises, restart per operation
	always @(posedge i_clk)
	begin
		ph1_r <= i_pins.ph1;
		last_r <= o_data;
		if (!i_pins.msc_n || !sel)
			cyc_r <= 3'h0;
		else if (i_pins.ph1 && !ph1_r)
			cyc_r <= cyc_r + 3'h1;
		if (!i_pins.strobe_n && !i_pins.rw && i_pins.doe)
			o_wr_data <= i_pins.dout;
	end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ews_pkg::*;
	typedef struct {logic [15:0] d; bit wr; bit chk; int lat; int w;} ews_exp_t;
	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	ews_req_t    i_req = '0;
	logic        i_ready;
	logic [15:0] i_data_in;
	logic        o_accept;
	logic        o_done;
	logic [15:0] o_rdata;
	logic [7:0]  o_wait_count;
	ews_pins_t   o_pins;
	logic [15:0] wr_data;
	logic [7:0]  last_wc = 8'h00;
	logic [15:0] lfsr = 16'h4A23;
	int          failures = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          t0;
	ews_exp_t    em;
	ews_exp_t    exp_q[$];
	int          acc_q[$];

	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;

	ews_bus_ctrl i_dut(.i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req),
		.i_ready(i_ready), .i_data_in(i_data_in), .o_accept(o_accept),
		.o_done(o_done), .o_rdata(o_rdata), .o_wait_count(o_wait_count),
		.o_pins(o_pins));
	ews_mem_model i_mem(.i_clk(i_clk), .i_pins(o_pins), .o_ready(i_ready),
		.o_data(i_data_in), .o_wr_data(wr_data));

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] want);
		n_compared++;
		if (got !== want)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	task automatic summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// present one request, note its result, wait until taken
	task automatic access(input logic we, input logic onc, input logic [1:0] sp,
		input logic [15:0] a, input logic [15:0] d);
		ews_exp_t e;
		e.d = we ? d : ~a;
		e.wr = we;
		e.chk = !onc;
		e.w = (onc || a[15]) ? 0 : int'(a[14:13]) + 1;
		e.lat = 28 * (e.w + 1) + 1;
		i_req <= '{1'b1, we, onc, ews_space_t'(sp), a, d};
		exp_q.push_back(e);
		for (int n = 0; n < 200; n++)
		begin
			@(posedge i_clk);
			if (o_accept === 1'b1)
				break;
		end
	endtask

	task automatic drain;
		i_req.req <= 1'b0;
		for (int n = 0; n < 400 && exp_q.size() > 0; n++)
			@(posedge i_clk);
		// an access never taken or never finished counts as a mismatch
		if (exp_q.size() > 0)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h want=%h", $time, exp_q.size(), 0);
			exp_q.delete();
		end
	endtask

	// pop the oldest note at each finished access
	always @(posedge i_clk)
	begin
		// wait count of the ending access, before a back-to-back start clears it
		last_wc <= o_wait_count;
		if (o_accept === 1'b1)
			acc_q.push_back(cyc);
		if (o_done === 1'b1 && exp_q.size() > 0 && acc_q.size() > 0)
		begin
			em = exp_q.pop_front();
			t0 = acc_q.pop_front();
			check(16'(cyc - t0), 16'(em.lat));
			check(16'(last_wc), 16'(em.w));
			if (em.chk)
				check(em.wr ? wr_data : o_rdata, em.d);
		end
	end

	initial
	begin
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		// every space and direction, zero and four waits, back to back
		for (int i = 0; i < 12; i++)
			access(1'((i / 3) % 2), 1'b0, 2'(i % 3),
				i < 6 ? 16'(16'h8000 + i) : 16'(16'h6001 + i), 16'(i * 16'h1111));
		access(1'b0, 1'b1, 2'h0, 16'h0000, 16'h0000);
		access(1'b1, 1'b1, 2'h1, 16'h0000, 16'h1234);
		drain();
		$display("test directed done");
		// random traffic
		repeat (30)
		begin
			lfsr = lfsr_next(lfsr);
			t0 = 32'(lfsr);
			lfsr = lfsr_next(lfsr);
			access(lfsr[0], lfsr[1] & lfsr[2], 2'(lfsr[4:3] % 2'h3), 16'(t0), lfsr);
		end
		drain();
		$display("test random done");
		summarize();
	end

	// watchdog well beyond the expected run
	initial
	begin
		#100000;
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
